// ===== rtl/adcsq_pkg.sv
// constants and types shared by the converter control block
package adcsq_pkg;

    // ==========================================================
    // configuration word layout
    localparam int CFG_W = 12;
    localparam int RES_W = 12;
    localparam int CH_W = 2;
    localparam int PM_HI = 11;
    localparam int PM_LO = 10;
    localparam int CODING_BIT = 9;
    localparam int REFSEL_BIT = 8;
    localparam int PICK_HI = 6;
    localparam int PICK_LO = 5;
    localparam int ITYPE_HI = 4;
    localparam int ITYPE_LO = 3;
    localparam int SCAN_HI = 2;
    localparam int SCAN_LO = 1;
    localparam int RANGE_BIT = 0;
    localparam logic [CFG_W-1:0] CFG_RESET = 12'h000;

    // ==========================================================
    // field encodings, written as {hi, lo}
    localparam logic [1:0] PM_NORMAL = 2'h0;
    localparam logic [1:0] PM_AUTO_SHUT = 2'h1;
    localparam logic [1:0] PM_AUTO_STBY = 2'h2;
    localparam logic [1:0] PM_FULL_SHUT = 2'h3;
    localparam logic [1:0] IT_SINGLE = 2'h0;
    localparam logic [1:0] IT_PSEUDO = 2'h1;
    localparam logic [1:0] IT_DIFF = 2'h2;
    localparam logic [1:0] SCAN_OFF = 2'h0;
    localparam logic [1:0] SCAN_ON = 2'h3;
    localparam logic [CH_W-1:0] CH_FIRST = 2'h0;
    localparam logic [CH_W:0] STEP_SINGLE = 3'h1;
    localparam logic [CH_W:0] STEP_PAIR = 3'h2;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_CLOCKS = 13;
    localparam int WAKE_INT_NS = 7000;
    localparam int WAKE_EXT_NS = 600;
    localparam int WAKE_SHUT_NS = 7000;
    localparam int CNT_W = 4;
    localparam int WK_W = 10;
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CLOCKS - 1);
    localparam logic [WK_W-1:0] WAKE_INT_CYC =
        WK_W'((WAKE_INT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [WK_W-1:0] WAKE_EXT_CYC =
        WK_W'((WAKE_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [WK_W-1:0] WAKE_SHUT_CYC =
        WK_W'((WAKE_SHUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ==========================================================
    // converter state, one-hot
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_SLEEP = 4'h2,
        ST_WAKE  = 4'h4,
        ST_CONV  = 4'h8
    } adcsq_state_e;

endpackage : adcsq_pkg

// ===== rtl/adcsq_sync.sv
// three-stage input synchroniser with agreement filter, one per bit
`timescale 1ns/100ps
module adcsq_sync
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_q
);

    // ==========================================================
    // per-bit chain
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++)
        begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic out_q;
            // first stage feeds only the second stage
            always_ff @(posedge clk)
            begin
                if (!rstn)
                begin
                    s1_q <= RST_VAL[gi];
                    s2_q <= RST_VAL[gi];
                    s3_q <= RST_VAL[gi];
                    out_q <= RST_VAL[gi];
                end
                else
                begin
                    s1_q <= async_in[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q)
                        out_q <= s3_q; // change counts once stages agree
                end
            end
            // one driver per output bit
            assign sync_q[gi] = out_q;
        end
    endgenerate

endmodule : adcsq_sync

// ===== rtl/adcsq_top.sv
// converter control: configuration word, power modes, channel sequencer
// Behaviour
// - power modes 00: everything stays powered, no power-down between conversions.
// - mode 01: all circuitry powers down at the end of each conversion.
// - mode 10: reference on, buffer partial, rest off; wake 7 us or 600 ns.
// - mode 11: all circuitry off, configuration word kept.
// - input type 00: single-ended, pick selects positive input, negative grounded.
// - input type 10: pairs (0,1),(1,0),(2,3),(3,2) for pick 0..3.
// - input type 01: pseudo differential, same pair mapping.
// - a conversion needs 13 full conversion clocks, otherwise it aborts.
// - scan 00: each conversion uses the pick bits of the last write.
// - scan 11: convert channels 0 up to the pick value in turn.
// - scanning in pair modes skips inverse pairs.
// - sequencer advances on every falling edge of sample start, except in full shutdown (mode 11).
// - result is straight binary or twos complement per coding bit.
// - twelve-bit write-only word loaded by chip select and write strobe.
// - word clears to zero at power-up; fixed bit layout.
// - coding bit 0 straight binary, 1 twos complement.
// - reference bit 1 internal, 0 external; sets standby wake time.
`timescale 1ns/100ps
module adcsq_top
    import adcsq_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic [CFG_W-1:0] data_in,
    input wire logic sample_start_n,
    input wire logic conversion_clock,
    input wire logic [RES_W-1:0] sar_code,
    output logic core_power_on,
    output logic ref_power_on,
    output logic ref_buf_full,
    output logic ref_buf_partial,
    output logic ref_internal_q,
    output logic range_double_q,
    output logic converting,
    output logic [CH_W-1:0] pos_sel_q,
    output logic [CH_W-1:0] neg_sel_q,
    output logic neg_to_ground_q,
    output logic conv_done_q,
    output logic conv_abort_q,
    output logic [RES_W-1:0] result_q
);

    // ==========================================================
    // pin synchronisers
    logic [CFG_W+3:0] pins_s;
    logic cs_s, wr_s, start_s, cclk_s;
    logic [CFG_W-1:0] data_s;

    adcsq_sync #(.W(CFG_W + 4), .RST_VAL({4'hf, CFG_RESET})) u_sync (
        .clk(clk),
        .rstn(rstn),
        .async_in({cs_n, wr_n, sample_start_n, conversion_clock, data_in}),
        .sync_q(pins_s)
    );
    assign {cs_s, wr_s, start_s, cclk_s, data_s} = pins_s;

    // ==========================================================
    // edge detection on synchronised pins
    logic wr_prev_q, start_prev_q, cclk_prev_q;
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            wr_prev_q <= 1'b1;
            start_prev_q <= 1'b1;
            cclk_prev_q <= 1'b1;
        end
        else
        begin
            wr_prev_q <= wr_s;
            start_prev_q <= start_s;
            cclk_prev_q <= cclk_s;
        end
    end
    wire cfg_write = !cs_s && wr_s && !wr_prev_q; // word taken at end of strobe
    wire start_fall = start_prev_q && !start_s;
    wire cclk_fall = cclk_prev_q && !cclk_s;

    // ==========================================================
    // configuration word, write only, clears at reset
    logic [CFG_W-1:0] cfg_q;
    always_ff @(posedge clk)
    begin
        if (!rstn)
            cfg_q <= CFG_RESET;
        else if (cfg_write)
            cfg_q <= data_s; // kept in every power mode
    end

    // field decode
    wire [1:0] pm = cfg_q[PM_HI:PM_LO];
    wire [1:0] itype = cfg_q[ITYPE_HI:ITYPE_LO];
    wire [1:0] scan = cfg_q[SCAN_HI:SCAN_LO];
    wire [CH_W-1:0] pick = cfg_q[PICK_HI:PICK_LO];
    wire coding_twos = cfg_q[CODING_BIT];
    wire ref_int = cfg_q[REFSEL_BIT];
    wire paired = (itype == IT_DIFF) || (itype == IT_PSEUDO);
    wire scanning = (scan == SCAN_ON); // mixed settings act as no scan
    wire full_shut = (pm == PM_FULL_SHUT);
    assign ref_internal_q = ref_int;
    assign range_double_q = cfg_q[RANGE_BIT];

    // ==========================================================
    // channel sequencer
    logic [CH_W-1:0] scan_ptr_q;
    wire [CH_W:0] ptr_step = {1'b0, scan_ptr_q} + (paired ? STEP_PAIR : STEP_SINGLE);
    wire ptr_wrap = ptr_step > {1'b0, pick};
    wire [CH_W-1:0] ptr_next = ptr_wrap ? CH_FIRST : ptr_step[CH_W-1:0];
    wire [CH_W-1:0] conv_ch = scanning ? scan_ptr_q : pick;
    wire seq_step = start_fall && !full_shut;

    always_ff @(posedge clk)
    begin
        if (!rstn)
            scan_ptr_q <= CH_FIRST;
        else if (cfg_write)
            scan_ptr_q <= CH_FIRST; // every new word restarts at channel 0
        else if (seq_step && scanning)
            scan_ptr_q <= ptr_next;
    end

    // ==========================================================
    // input mux select, latched at sample start
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            pos_sel_q <= CH_FIRST;
            neg_sel_q <= CH_FIRST;
            neg_to_ground_q <= 1'b1;
        end
        else if (seq_step)
        begin
            pos_sel_q <= conv_ch;
            neg_sel_q <= conv_ch ^ {{(CH_W-1){1'b0}}, 1'b1}; // partner of the pair
            neg_to_ground_q <= !paired;
        end
    end

    // ==========================================================
    // power and conversion state machine
    adcsq_state_e state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [WK_W-1:0] wake_q, wake_d;
    logic done_d, abort_d;
    wire asleep_mode = (pm == PM_AUTO_SHUT) || (pm == PM_AUTO_STBY);
    wire [WK_W-1:0] wake_load = (pm == PM_AUTO_SHUT) ? WAKE_SHUT_CYC :
                                ref_int ? WAKE_INT_CYC : WAKE_EXT_CYC;
    wire conv_last = cclk_fall && (cnt_q == CONV_LAST);
    adcsq_state_e rest_state;
    assign rest_state = asleep_mode ? ST_SLEEP : ST_IDLE;

    // next state
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        wake_d = wake_q;
        done_d = 1'b0;
        abort_d = 1'b0;
        case (state_q)
            ST_IDLE:
            begin
                if (full_shut || asleep_mode)
                    state_d = ST_SLEEP;
                else if (start_fall)
                begin
                    state_d = ST_CONV;
                    cnt_d = '0;
                end
            end
            ST_SLEEP:
            begin
                if (pm == PM_NORMAL)
                    state_d = ST_IDLE;
                else if (start_fall && asleep_mode)
                begin
                    state_d = ST_WAKE;
                    wake_d = wake_load;
                end
            end
            ST_WAKE:
            begin
                if (full_shut)
                    state_d = ST_SLEEP;
                else if (wake_q <= {{(WK_W-1){1'b0}}, 1'b1})
                begin
                    state_d = ST_CONV;
                    cnt_d = '0;
                end
                else
                    wake_d = wake_q - {{(WK_W-1){1'b0}}, 1'b1};
            end
            ST_CONV:
            begin
                if (full_shut || cfg_write)
                begin
                    abort_d = 1'b1; // short of 13 clocks
                    state_d = full_shut ? ST_SLEEP : ST_IDLE;
                end
                else if (start_fall)
                begin
                    abort_d = 1'b1; // new sample before completion
                    cnt_d = '0;
                end
                else if (conv_last)
                begin
                    done_d = 1'b1; // 13th full period
                    state_d = rest_state; // power down after each conversion in modes 01 and 10, stay idle in mode 00
                end
                else if (cclk_fall)
                    cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
            default:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            wake_q <= '0;
            conv_done_q <= 1'b0;
            conv_abort_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            wake_q <= wake_d;
            conv_done_q <= done_d;
            conv_abort_q <= abort_d;
        end
    end

    // ==========================================================
    // result coding, twos complement flips the top bit
    always_ff @(posedge clk)
    begin
        if (!rstn)
            result_q <= '0;
        else if (done_d)
            result_q <= coding_twos ? {~sar_code[RES_W-1], sar_code[RES_W-2:0]}
                                    : sar_code;
    end

    // ==========================================================
    // power enables
    wire awake = (state_q == ST_IDLE) || (state_q == ST_CONV) || (state_q == ST_WAKE);
    wire stby_sleep = (state_q == ST_SLEEP) && (pm == PM_AUTO_STBY);
    assign core_power_on = awake;
    assign ref_power_on = awake || stby_sleep;
    assign ref_buf_full = awake;
    assign ref_buf_partial = stby_sleep;
    assign converting = (state_q == ST_CONV);

    // ==========================================================
    // checks
    sequence s_wr_edge;
        !cs_s && !wr_prev_q && wr_s;
    endsequence
    sequence s_wake_conv;
        (state_q == ST_WAKE) ##1 (state_q == ST_CONV);
    endsequence

    property p_normal_on;
        @(posedge clk) disable iff (!rstn)
        (pm == PM_NORMAL) && $stable(pm) |=> core_power_on && ref_buf_full;
    endproperty
    a_normal_on: assert property (p_normal_on) else $error("normal mode lost power");

    property p_autoshut;
        @(posedge clk) disable iff (!rstn)
        conv_done_q && (pm == PM_AUTO_SHUT) |-> !core_power_on && !ref_power_on;
    endproperty
    a_autoshut: assert property (p_autoshut) else $error("no shutdown after conversion");

    property p_stby_wake;
        @(posedge clk) disable iff (!rstn)
        (state_q == ST_SLEEP) && (pm == PM_AUTO_STBY) && start_fall && !ref_int && !cfg_write
        |=> (state_q == ST_WAKE) ##59 (state_q == ST_WAKE) ##1 (state_q == ST_CONV);
    endproperty
    a_stby_wake: assert property (p_stby_wake) else $error("external wake time wrong");

    property p_stby_power;
        @(posedge clk) disable iff (!rstn)
        stby_sleep |-> ref_power_on && ref_buf_partial && !core_power_on;
    endproperty
    a_stby_power: assert property (p_stby_power) else $error("standby power wrong");

    property p_full_shut;
        @(posedge clk) disable iff (!rstn)
        full_shut ##1 full_shut |=> !core_power_on && !ref_power_on && $stable(cfg_q) || cfg_write;
    endproperty
    a_full_shut: assert property (p_full_shut) else $error("full shutdown wrong");

    property p_decode;
        @(posedge clk) disable iff (!rstn)
        seq_step |=> (neg_to_ground_q == (itype == IT_SINGLE) || $changed(cfg_q))
                     && (neg_sel_q == (pos_sel_q ^ 2'h1));
    endproperty
    a_decode: assert property (p_decode) else $error("input decode wrong");

    property p_conv_len;
        @(posedge clk) disable iff (!rstn)
        conv_done_q |-> $past(cnt_q) == CONV_LAST;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion not 13 clocks");

    property p_manual;
        @(posedge clk) disable iff (!rstn)
        seq_step && (scan == SCAN_OFF) |=> pos_sel_q == $past(pick);
    endproperty
    a_manual: assert property (p_manual) else $error("manual channel wrong");

    property p_scan_first;
        @(posedge clk) disable iff (!rstn)
        s_wr_edge |=> scan_ptr_q == CH_FIRST;
    endproperty
    a_scan_first: assert property (p_scan_first) else $error("scan not from 0");

    property p_skip_inverse;
        @(posedge clk) disable iff (!rstn)
        seq_step && scanning && paired |=> !pos_sel_q[0];
    endproperty
    a_skip_inverse: assert property (p_skip_inverse) else $error("inverse pair scanned");

    property p_scan_bound;
        @(posedge clk) disable iff (!rstn)
        scanning |-> scan_ptr_q <= pick || $past(cfg_write) || $changed(cfg_q);
    endproperty
    a_scan_bound: assert property (p_scan_bound) else $error("scan past final");

    property p_coding;
        @(posedge clk) disable iff (!rstn)
        done_d |=> result_q[RES_W-1] == ($past(sar_code[RES_W-1]) ^ $past(coding_twos));
    endproperty
    a_coding: assert property (p_coding) else $error("result coding wrong");

    property p_write;
        @(posedge clk) disable iff (!rstn)
        s_wr_edge |=> cfg_q == $past(data_s);
    endproperty
    a_write: assert property (p_write) else $error("word not loaded");

    property p_wake_done;
        @(posedge clk) disable iff (!rstn)
        s_wake_conv |-> cnt_q == '0;
    endproperty
    a_wake_done: assert property (p_wake_done) else $error("count not cleared");

endmodule : adcsq_top

// ===== tb/adcsq_host.sv
// host processor model driving the configuration port and conversion pins
`timescale 1ns/100ps
module adcsq_host
    import adcsq_pkg::*;
(
    input wire logic clk,
    output logic cs_n,
    output logic wr_n,
    output logic [CFG_W-1:0] data_in,
    output logic sample_start_n,
    output logic conversion_clock
);

    // ==========================================================
    // idle levels: strobes high, conversion clock parked high
    initial
    begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        data_in = 12'h000;
        sample_start_n = 1'b1;
        conversion_clock = 1'b1;
    end

    // wait a number of falling clock edges
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step

    // ==========================================================
    // one configuration write, strobes held long enough for the filter
    task automatic write_cfg(input logic [CFG_W-1:0] word);
        logic [CFG_W-1:0] w;
        w = word;
        if (w[ITYPE_HI:ITYPE_LO] == 2'h3)
        begin
            w[ITYPE_HI] = 1'b0; // input type 11 is never handed over
        end
        if (w[SCAN_HI] != w[SCAN_LO])
        begin
            w[SCAN_HI:SCAN_LO] = SCAN_OFF; // only scan 00 or 11 is written
        end
        @(negedge clk);
        cs_n = 1'b0; // word loaded by chip select and write strobe
        data_in = w;
        wr_n = 1'b0;
        step(6);
        wr_n = 1'b1; // word taken on the strobe's rising edge
        step(6);
        cs_n = 1'b1;
        data_in = ~w; // released bus no longer shows the word
        step(4);
    endtask : write_cfg

    // ==========================================================
    // start pulse, then a given number of conversion clock periods
    task automatic conv(input int np);
        @(negedge clk);
        sample_start_n = 1'b0;
        step(6);
        sample_start_n = 1'b1; // rising start edge precedes any reprogramming
        step(6);
        for (int i = 0; i < np; i++)
        begin
            conversion_clock = 1'b0;
            step(5);
            conversion_clock = 1'b1;
            step(5);
        end
        step(8);
    endtask : conv

endmodule : adcsq_host

// ===== tb/adcsq_top_test.sv
// self-checking testbench of the converter control block
`timescale 1ns/100ps
module adcsq_top_test
    import adcsq_pkg::*;
;
    logic clk = 1'b0;
    logic rstn;
    logic cs_n, wr_n, sample_start_n, conversion_clock;
    logic [CFG_W-1:0] data_in;
    logic [RES_W-1:0] sar_code;
    logic core_power_on, ref_power_on, ref_buf_full, ref_buf_partial;
    logic ref_internal_q, range_double_q, converting, neg_to_ground_q;
    logic conv_done_q, conv_abort_q;
    logic [CH_W-1:0] pos_sel_q, neg_sel_q;
    logic [RES_W-1:0] result_q;
    int fail_count = 0;
    int compares = 0;
    int done_cnt = 0;
    int abort_cnt = 0;

    // ==========================================================
    // clock, pulse counters and instances
    always #5 clk = ~clk;

    always @(posedge clk)
    begin
        if (conv_done_q === 1'b1) done_cnt <= done_cnt + 1;
        if (conv_abort_q === 1'b1) abort_cnt <= abort_cnt + 1;
    end

    adcsq_host adcsq_host_i (.clk(clk), .cs_n(cs_n), .wr_n(wr_n), .data_in(data_in),
        .sample_start_n(sample_start_n), .conversion_clock(conversion_clock));

    adcsq_top adcsq_top_i (.clk(clk), .rstn(rstn), .cs_n(cs_n), .wr_n(wr_n),
        .data_in(data_in), .sample_start_n(sample_start_n),
        .conversion_clock(conversion_clock), .sar_code(sar_code),
        .core_power_on(core_power_on), .ref_power_on(ref_power_on),
        .ref_buf_full(ref_buf_full), .ref_buf_partial(ref_buf_partial),
        .ref_internal_q(ref_internal_q), .range_double_q(range_double_q),
        .converting(converting), .pos_sel_q(pos_sel_q), .neg_sel_q(neg_sel_q),
        .neg_to_ground_q(neg_to_ground_q), .conv_done_q(conv_done_q),
        .conv_abort_q(conv_abort_q), .result_q(result_q));

    // ==========================================================
    // comparison, word builder, conversion helper, closing
    task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    function automatic logic [11:0] mk(input logic [1:0] pm, input logic cod, input logic rf,
        input logic [1:0] pick, input logic [1:0] it, input logic [1:0] sc, input logic rg);
        return {pm, cod, rf, 1'b0, pick, it, sc, rg};
    endfunction : mk

    task automatic conv_once(input int np, input int exp_done);
        int d;
        d = done_cnt;
        adcsq_host_i.conv(np);
        chk("conv_done_q count", 12'(done_cnt - d), 12'(exp_done));
    endtask : conv_once

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    // watchdog sized well above the expected run of about eight thousand cycles
    initial
    begin
        repeat (60000) @(posedge clk);
        fail_count++;
        end_sim;
    end

    // ==========================================================
    // test sequence
    initial
    begin
        int a;
        logic [1:0] p_keep;
        rstn = 1'b0;
        sar_code = 12'ha5c;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        chk("core_power_on", 12'(core_power_on), 12'h001);
        chk("neg_to_ground_q", 12'(neg_to_ground_q), 12'h001);
        chk("result_q", result_q, 12'h000);
        chk("ref and range", 12'({ref_internal_q, range_double_q}), 12'h000);
        $display("test reset finished");
        for (int p = 0; p < 4; p++)
        begin
            adcsq_host_i.write_cfg(mk(PM_NORMAL, p[0], 1'b1, p[1:0], IT_SINGLE, SCAN_OFF, p[1]));
            chk("ref_internal_q", 12'(ref_internal_q), 12'h001);
            chk("range_double_q", 12'(range_double_q), 12'(p[1]));
            conv_once(13, 1);
            chk("converting", 12'(converting), 12'h000);
            chk("pos_sel_q", 12'(pos_sel_q), 12'(p));
            chk("neg_to_ground_q", 12'(neg_to_ground_q), 12'h001);
            chk("result_q", result_q, p[0] ? 12'h25c : 12'ha5c);
            chk("core_power_on", 12'(core_power_on), 12'h001);
        end
        $display("test single ended finished");
        for (int m = 0; m < 2; m++)
        begin
            for (int p = 0; p < 4; p++)
            begin
                adcsq_host_i.write_cfg(mk(PM_NORMAL, 1'b0, 1'b0, p[1:0],
                    (m == 0) ? IT_DIFF : IT_PSEUDO, SCAN_OFF, 1'b0));
                conv_once(13, 1);
                chk("pos_sel_q", 12'(pos_sel_q), 12'(p));
                chk("neg_sel_q", 12'(neg_sel_q), 12'(p ^ 1));
                chk("neg_to_ground_q", 12'(neg_to_ground_q), 12'h000);
            end
        end
        $display("test pair decode finished");
        adcsq_host_i.write_cfg(mk(PM_NORMAL, 1'b0, 1'b0, 2'h2, IT_SINGLE, SCAN_ON, 1'b0));
        for (int i = 0; i < 5; i++)
        begin
            conv_once(13, 1);
            chk("scan pos_sel_q", 12'(pos_sel_q), 12'(i % 3));
        end
        adcsq_host_i.write_cfg(mk(PM_NORMAL, 1'b0, 1'b0, 2'h3, IT_DIFF, SCAN_ON, 1'b0));
        for (int i = 0; i < 4; i++)
        begin
            conv_once(13, 1);
            chk("pair scan pos_sel_q", 12'(pos_sel_q), 12'((i % 2) * 2));
        end
        $display("test scan finished");
        adcsq_host_i.write_cfg(mk(PM_NORMAL, 1'b0, 1'b0, 2'h1, IT_SINGLE, SCAN_OFF, 1'b0));
        conv_once(12, 0);
        chk("converting", 12'(converting), 12'h001);
        a = abort_cnt;
        conv_once(13, 1);
        chk("abort count", 12'(abort_cnt - a), 12'h001);
        $display("test short conversion finished");
        adcsq_host_i.write_cfg(mk(PM_AUTO_SHUT, 1'b0, 1'b1, 2'h0, IT_SINGLE, SCAN_OFF, 1'b0));
        for (int i = 0; i < 2; i++)
        begin
            conv_once(90, 1);
            chk("shut power", 12'({core_power_on, ref_power_on}), 12'h000);
        end
        for (int r = 0; r < 2; r++)
        begin
            adcsq_host_i.write_cfg(mk(PM_AUTO_STBY, 1'b0, r[0], 2'h0, IT_SINGLE, SCAN_OFF,
                1'b0));
            conv_once(90, 1);
            chk("standby power",
                12'({core_power_on, ref_power_on, ref_buf_full, ref_buf_partial}),
                12'h005);
        end
        $display("test power down modes finished");
        p_keep = pos_sel_q;
        adcsq_host_i.write_cfg(mk(PM_FULL_SHUT, 1'b1, 1'b1, 2'h2, IT_SINGLE, SCAN_OFF, 1'b1));
        chk("full shut power", 12'({core_power_on, ref_power_on}), 12'h000);
        conv_once(20, 0);
        chk("pos_sel_q held", 12'(pos_sel_q), 12'(p_keep));
        chk("word kept", 12'({ref_internal_q, range_double_q}), 12'h003);
        $display("test full shutdown finished");
        end_sim;
    end

endmodule : adcsq_top_test
